// >>> byte_fifo.sv
// shift-register fifo, head entry is a flop so outputs are registered
`timescale 1ns/1ps
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic sys_clk,
    input wire logic reset,
    byte_stream_if.snk wr,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int CW = $clog2(DEPTH + 1);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [CW-1:0] cnt;
        logic full;
        logic valid;
    } fifo_t;
    fifo_t r, r_nxt;

    // pop shifts everything down, push lands behind the last entry
    always_comb begin
        logic pop;
        logic push;
        pop = out_ready & r.valid;
        push = wr.valid & ~r.full;
        r_nxt = r;
        if (pop) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                r_nxt.mem[i] = r.mem[i + 1];
            end
            r_nxt.cnt = r.cnt - CW'(1);
        end
        if (push) begin
            r_nxt.mem[r_nxt.cnt] = wr.data;
            r_nxt.cnt = r_nxt.cnt + CW'(1);
        end
        r_nxt.valid = (r_nxt.cnt != '0);
        r_nxt.full = (r_nxt.cnt == CW'(DEPTH));
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            r <= '0;
        end else begin
            r <= r_nxt;
        end
    end

    assign wr.ready = ~r.full;
    assign out_data = r.mem[0];
    assign out_valid = r.valid;
endmodule : byte_fifo

// >>> byte_stream_if.sv
// valid/ready byte stream between the sequencer and the read fifo
`timescale 1ns/1ps
interface byte_stream_if #(parameter int W = 8) ();
    logic [W-1:0] data;
    logic valid;
    logic ready;
    modport src(output data, output valid, input ready);
    modport snk(input data, input valid, output ready);
endinterface : byte_stream_if

// >>> nand_flash_model.sv
// behavioural flash device on the far side of the host pins
`timescale 1ns/1ps
module nand_flash_model #(
    parameter int BUSY_NS = 2000
) (
    input logic command_latch_en,
    input logic address_latch_en,
    input logic chip_en_n,
    input logic write_strobe_n,
    input logic read_strobe_n,
    input logic write_protect_n,
    input logic [7:0] io_bus_out,
    output logic [7:0] io_drive,
    output logic busy_pull
);
    // power-on leaves the read command latched
    logic [7:0] cmd_r = 8'h00;
    logic [12:0] col_r = 13'h0;
    logic [16:0] row_r = 17'h0;
    logic [2:0] acnt_r = 3'h0;
    initial io_drive = 8'h5a;
    initial busy_pull = 1'b0;
    // latch on write strobe rise; only status or reset while busy
    always @(posedge write_strobe_n) begin
        if (!chip_en_n && command_latch_en && (!busy_pull || io_bus_out inside {8'h70, 8'h71, 8'hff})) begin
            cmd_r <= io_bus_out;
            acnt_r <= (io_bus_out == 8'h60) ? 3'h2 : 3'h0;
            // open drain pull-down for the whole transfer
            if (io_bus_out == 8'h30 || io_bus_out == 8'hff) begin
                busy_pull <= 1'b1;
                busy_pull <= #(io_bus_out == 8'h30 ? BUSY_NS : 200) 1'b0;
            end
        end else if (!chip_en_n && address_latch_en && !busy_pull) begin
            // column low, column high, then three row bytes
            case (acnt_r)
                3'h0: col_r[7:0] <= io_bus_out;
                3'h1: col_r[12:8] <= io_bus_out[4:0];
                3'h2: row_r[7:0] <= io_bus_out;
                3'h3: row_r[15:8] <= io_bus_out;
                default: row_r[16] <= io_bus_out[0];
            endcase
            acnt_r <= acnt_r + 3'h1;
        end
    end
    // a byte per read strobe fall, column advances on array data reads only
    always @(negedge read_strobe_n) begin
        if (cmd_r inside {8'h70, 8'h71}) begin
            io_drive <= #20 {write_protect_n, ~busy_pull, ~busy_pull, 5'h00};
        end else if (cmd_r == 8'h7a) begin
            io_drive <= #20 8'h00;
        end else begin
            io_drive <= #20 col_r[7:0] + row_r[7:0];
            col_r <= col_r + 13'h1;
        end
    end
    // released bus must not keep the last byte
    always @(posedge read_strobe_n) io_drive <= #25 ~io_drive;
endmodule : nand_flash_model

// >>> nand_host.sv
// host sequencer driving a nand flash over its strobe and bus pins
// Behaviour
// - address is five byte cycles: two column, three row, low byte first
// - column bits 0-7 first cycle, bits 8-12 second, top three lines low
// - row bytes in cycles three to five, bit 16 alone in fifth
// - cycle type decoded from latch enables, chip enable and strobes
// - during busy only reset or status may be issued
// - page read is 00h, five address cycles, then 30h
// - 05h, two column cycles, E0h move the output column
// - multi read: 60h plus row, 60h plus row, then 30h
// - multi read: one block per district, same page-in-block bits
// - ecc status only after single page read, never after multi read (host refuses it only when the last read was a multi read)
`timescale 1ns/1ps
module nand_host #(
    parameter int FIFO_DEPTH = 8
) (
    input wire logic sys_clk,
    input wire logic reset,
    // command port
    input wire logic cmd_valid,
    input wire nand_host_pkg::op_t cmd_op,
    input wire logic [nand_host_pkg::COL_W-1:0] cmd_col,
    input wire logic [nand_host_pkg::ROW_W-1:0] cmd_row,
    input wire logic [nand_host_pkg::ROW_W-1:0] cmd_row2,
    input wire logic [12:0] cmd_count,
    input wire logic write_allow,
    output logic cmd_ready,
    output logic cmd_error,
    output logic cmd_done,
    // read data
    output logic [7:0] rd_data,
    output logic rd_valid,
    input wire logic rd_ready,
    // flash pins
    output logic command_latch_en,
    output logic address_latch_en,
    output logic chip_en_n,
    output logic write_strobe_n,
    output logic read_strobe_n,
    output logic write_protect_n,
    output logic [7:0] io_bus_out,
    output logic io_bus_oe,
    input wire logic [7:0] io_bus_in,
    input wire logic ready_busy_n
);
    typedef struct packed {
        nand_host_pkg::state_t st;
        nand_host_pkg::op_t op;
        logic [3:0] ph;
        logic [7:0] cnt;
        logic [12:0] left;
        logic [nand_host_pkg::COL_W-1:0] col;
        logic [nand_host_pkg::ROW_W-1:0] row;
        logic [nand_host_pkg::ROW_W-1:0] row2;
        logic last_multi;
        logic cle;
        logic ale;
        logic ce_n;
        logic we_n;
        logic re_n;
        logic wp_n;
        logic [7:0] io_out;
        logic io_oe;
        logic push;
        logic [7:0] push_data;
        logic ready;
        logic error;
        logic done;
    } host_t;
    host_t r, r_nxt;

    logic rb_s;
    logic [7:0] io_s;
    logic [9:0] step;

    byte_stream_if #(.W(8)) push_if ();

    // pins from outside the clock domain pass two flops first
    pin_sync #(.W(1)) u_rb_sync (
        .sys_clk(sys_clk),
        .reset(reset),
        .d(ready_busy_n),
        .q(rb_s)
    );

    pin_sync #(.W(8)) u_io_sync (
        .sys_clk(sys_clk),
        .reset(reset),
        .d(io_bus_in),
        .q(io_s)
    );

    byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .sys_clk(sys_clk),
        .reset(reset),
        .wr(push_if.snk),
        .out_data(rd_data),
        .out_valid(rd_valid),
        .out_ready(rd_ready)
    );

    assign push_if.data = r.push_data;
    assign push_if.valid = r.push;

    // byte for bus cycle ph of an operation: {is_addr, is_last, byte}
    function automatic logic [9:0] step_byte(
        input nand_host_pkg::op_t op,
        input logic [3:0] ph,
        input logic [nand_host_pkg::COL_W-1:0] col,
        input logic [nand_host_pkg::ROW_W-1:0] row,
        input logic [nand_host_pkg::ROW_W-1:0] row2
    );
        logic [7:0] c_lo;
        logic [7:0] c_hi;
        logic [7:0] r0;
        logic [7:0] r1;
        logic [7:0] r2;
        logic [7:0] s0;
        logic [7:0] s1;
        logic [7:0] s2;
        c_lo = col[7:0];
        c_hi = {3'b000, col[12:8]};
        r0 = row[7:0];
        r1 = row[15:8];
        r2 = {7'b0000000, row[16]};
        s0 = row2[7:0];
        s1 = row2[15:8];
        s2 = {7'b0000000, row2[16]};
        step_byte = {2'b01, nand_host_pkg::CMD_RESET};
        case (op)
            nand_host_pkg::OP_READ: begin
                // 00h, five address cycles, 30h
                case (ph)
                    4'h0: step_byte = {2'b00, nand_host_pkg::CMD_READ};
                    4'h1: step_byte = {2'b10, c_lo};
                    4'h2: step_byte = {2'b10, c_hi};
                    4'h3: step_byte = {2'b10, r0};
                    4'h4: step_byte = {2'b10, r1};
                    4'h5: step_byte = {2'b10, r2};
                    default: step_byte = {2'b01, nand_host_pkg::CMD_READ_GO};
                endcase
            end
            nand_host_pkg::OP_COLCHG: begin
                // column move without array read
                case (ph)
                    4'h0: step_byte = {2'b00, nand_host_pkg::CMD_COL_OUT};
                    4'h1: step_byte = {2'b10, c_lo};
                    4'h2: step_byte = {2'b10, c_hi};
                    default: step_byte = {2'b01, nand_host_pkg::CMD_COL_OUT_GO};
                endcase
            end
            nand_host_pkg::OP_MULTI: begin
                // row for each district, then one confirm
                case (ph)
                    4'h0: step_byte = {2'b00, nand_host_pkg::CMD_ROW_SEL};
                    4'h1: step_byte = {2'b10, r0};
                    4'h2: step_byte = {2'b10, r1};
                    4'h3: step_byte = {2'b10, r2};
                    4'h4: step_byte = {2'b00, nand_host_pkg::CMD_ROW_SEL};
                    4'h5: step_byte = {2'b10, s0};
                    4'h6: step_byte = {2'b10, s1};
                    4'h7: step_byte = {2'b10, s2};
                    default: step_byte = {2'b01, nand_host_pkg::CMD_READ_GO};
                endcase
            end
            nand_host_pkg::OP_STATUS: step_byte = {2'b01, nand_host_pkg::CMD_STATUS};
            nand_host_pkg::OP_ECC: step_byte = {2'b01, nand_host_pkg::CMD_ECC};
            default: step_byte = {2'b01, nand_host_pkg::CMD_RESET};
        endcase
    endfunction : step_byte

    assign step = step_byte(r.op, r.ph, r.col, r.row, r.row2);

    // sequencer: command/address writes, busy wait, strobed reads
    always_comb begin
        logic legal;
        logic busy_ok;
        r_nxt = r;
        r_nxt.push = 1'b0;
        r_nxt.error = 1'b0;
        r_nxt.done = 1'b0;
        r_nxt.wp_n = write_allow;
        legal = 1'b1;
        busy_ok = 1'b1;
        case (r.st)
            nand_host_pkg::S_IDLE: begin
                r_nxt.ce_n = 1'b1; // standby while idle
                if (cmd_valid && r.ready) begin
                    // ecc status is refused after a multi read
                    if (cmd_op == nand_host_pkg::OP_ECC && r.last_multi) begin
                        legal = 1'b0;
                    end
                    // same page bits, one block in each district
                    if (cmd_op == nand_host_pkg::OP_MULTI &&
                        (cmd_row[nand_host_pkg::PAGE_BITS-1:0] != cmd_row2[nand_host_pkg::PAGE_BITS-1:0] ||
                         cmd_row[nand_host_pkg::DISTRICT_BIT] == cmd_row2[nand_host_pkg::DISTRICT_BIT])) begin
                        legal = 1'b0;
                    end
                    // only reset or status while the device is busy
                    if (!rb_s && cmd_op != nand_host_pkg::OP_RESET && cmd_op != nand_host_pkg::OP_STATUS) begin
                        busy_ok = 1'b0;
                    end
                    if (legal && busy_ok) begin
                        r_nxt.op = cmd_op;
                        r_nxt.col = cmd_col;
                        r_nxt.row = cmd_row;
                        r_nxt.row2 = cmd_row2;
                        r_nxt.left = (cmd_op == nand_host_pkg::OP_STATUS) ? 13'h0001 : cmd_count;
                        r_nxt.ph = 4'h0;
                        r_nxt.ce_n = 1'b0;
                        r_nxt.ready = 1'b0;
                        r_nxt.st = nand_host_pkg::S_SETUP;
                        if (cmd_op == nand_host_pkg::OP_MULTI) begin
                            r_nxt.last_multi = 1'b1;
                        end else if (cmd_op == nand_host_pkg::OP_READ) begin
                            r_nxt.last_multi = 1'b0;
                        end
                    end else begin
                        r_nxt.error = 1'b1;
                    end
                end
            end
            nand_host_pkg::S_SETUP: begin
                // latch enable and byte set up as the write strobe falls
                r_nxt.cle = ~step[9];
                r_nxt.ale = step[9];
                r_nxt.io_out = step[7:0];
                r_nxt.io_oe = 1'b1;
                r_nxt.we_n = 1'b0;
                r_nxt.cnt = 8'(nand_host_pkg::WP_CYC - 1);
                r_nxt.st = nand_host_pkg::S_WE_LOW;
            end
            nand_host_pkg::S_WE_LOW: begin
                if (r.cnt == 8'h00) begin
                    r_nxt.we_n = 1'b1; // byte latches on this rise
                    r_nxt.cnt = 8'(nand_host_pkg::WH_CYC - 1);
                    r_nxt.st = nand_host_pkg::S_WE_HIGH;
                end else begin
                    r_nxt.cnt = r.cnt - 8'h01;
                end
            end
            nand_host_pkg::S_WE_HIGH: begin
                if (r.cnt != 8'h00) begin
                    r_nxt.cnt = r.cnt - 8'h01;
                end else begin
                    r_nxt.cle = 1'b0;
                    r_nxt.ale = 1'b0;
                    r_nxt.io_oe = 1'b0;
                    if (!step[8]) begin
                        r_nxt.ph = r.ph + 4'h1;
                        r_nxt.st = nand_host_pkg::S_SETUP;
                    end else if (r.op == nand_host_pkg::OP_READ || r.op == nand_host_pkg::OP_MULTI ||
                                 r.op == nand_host_pkg::OP_RESET) begin
                        // array work started by the confirm rise
                        r_nxt.cnt = 8'(nand_host_pkg::WB_CYC - 1);
                        r_nxt.st = nand_host_pkg::S_BUSY;
                    end else begin
                        r_nxt.cnt = 8'(nand_host_pkg::WHR_CYC - 1);
                        r_nxt.st = nand_host_pkg::S_GAP;
                    end
                end
            end
            nand_host_pkg::S_BUSY: begin
                // strobes stay high until ready returns
                if (r.cnt != 8'h00) begin
                    r_nxt.cnt = r.cnt - 8'h01;
                end else if (rb_s) begin
                    r_nxt.cnt = 8'(nand_host_pkg::RR_CYC - 1);
                    r_nxt.st = nand_host_pkg::S_GAP;
                end
            end
            nand_host_pkg::S_GAP: begin
                if (r.cnt != 8'h00) begin
                    r_nxt.cnt = r.cnt - 8'h01;
                end else if (r.op == nand_host_pkg::OP_RESET || r.left == 13'h0000) begin
                    r_nxt.ready = 1'b1;
                    r_nxt.done = 1'b1;
                    r_nxt.st = nand_host_pkg::S_IDLE;
                end else begin
                    r_nxt.re_n = 1'b0; // first output byte
                    r_nxt.cnt = 8'(nand_host_pkg::RE_LOW_CYC - 1);
                    r_nxt.st = nand_host_pkg::S_RE_LOW;
                end
            end
            nand_host_pkg::S_RE_LOW: begin
                // a full fifo holds the strobe low, so the device waits
                if (r.cnt != 8'h00) begin
                    r_nxt.cnt = r.cnt - 8'h01;
                end else if (push_if.ready) begin
                    r_nxt.push = 1'b1;
                    r_nxt.push_data = io_s;
                    r_nxt.re_n = 1'b1;
                    r_nxt.left = r.left - 13'h0001; // device column steps too, except on status and ecc reads
                    r_nxt.cnt = 8'(nand_host_pkg::REH_CYC - 1);
                    r_nxt.st = nand_host_pkg::S_RE_HIGH;
                end
            end
            nand_host_pkg::S_RE_HIGH: begin
                if (r.cnt != 8'h00) begin
                    r_nxt.cnt = r.cnt - 8'h01;
                end else if (r.left == 13'h0000) begin
                    r_nxt.ready = 1'b1;
                    r_nxt.done = 1'b1;
                    r_nxt.st = nand_host_pkg::S_IDLE;
                end else begin
                    r_nxt.re_n = 1'b0;
                    r_nxt.cnt = 8'(nand_host_pkg::RE_LOW_CYC - 1);
                    r_nxt.st = nand_host_pkg::S_RE_LOW;
                end
            end
            default: begin
                r_nxt.st = nand_host_pkg::S_IDLE;
            end
        endcase
    end

    // strobes and chip enable rest high out of reset
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            r <= '0;
            r.ce_n <= 1'b1;
            r.we_n <= 1'b1;
            r.re_n <= 1'b1;
            r.ready <= 1'b1;
        end else begin
            r <= r_nxt;
        end
    end

    assign cmd_ready = r.ready;
    assign cmd_error = r.error;
    assign cmd_done = r.done;
    assign command_latch_en = r.cle;
    assign address_latch_en = r.ale;
    assign chip_en_n = r.ce_n;
    assign write_strobe_n = r.we_n;
    assign read_strobe_n = r.re_n;
    assign write_protect_n = r.wp_n;
    assign io_bus_out = r.io_out;
    assign io_bus_oe = r.io_oe;
endmodule : nand_host

// >>> nand_host_pkg.sv
// constants, commands and types shared by the flash host controller
package nand_host_pkg;
    // bus clock and pin timing, in their own units
    localparam int CLK_MHZ = 40;
    localparam int T_WP_NS = 12;
    localparam int T_WH_NS = 10;
    localparam int T_WHR_NS = 60;
    localparam int T_WB_NS = 100;
    localparam int T_RR_NS = 20;
    localparam int T_REA_NS = 20;
    localparam int T_REH_NS = 10;
    localparam int SYNC_STAGES = 2;

    // least times round up, never below one cycle
    function automatic int cyc_ceil(input int ns);
        int c;
        c = (ns * CLK_MHZ + 999) / 1000;
        return (c < 1) ? 1 : c;
    endfunction : cyc_ceil

    localparam int WP_CYC = cyc_ceil(T_WP_NS);
    localparam int WH_CYC = cyc_ceil(T_WH_NS);
    localparam int WHR_CYC = cyc_ceil(T_WHR_NS);
    localparam int WB_CYC = cyc_ceil(T_WB_NS);
    localparam int RR_CYC = cyc_ceil(T_RR_NS);
    localparam int REH_CYC = cyc_ceil(T_REH_NS);
    // strobe held low until the synchronised pin value is settled
    localparam int RE_LOW_CYC = cyc_ceil(T_REA_NS) + SYNC_STAGES + 1;

    // geometry
    localparam int COL_W = 13;
    localparam int ROW_W = 17;
    localparam int PAGE_BITS = 6;
    localparam int DISTRICT_BIT = 6;
    localparam int PAGE_BYTES = 4224;
    localparam int MAIN_BYTES = 4096;
    localparam int ADDR_CYCLES = 5;

    // command codes
    localparam logic [7:0] CMD_READ = 8'h00;
    localparam logic [7:0] CMD_READ_GO = 8'h30;
    localparam logic [7:0] CMD_COPY_READ = 8'h35;
    localparam logic [7:0] CMD_COL_OUT = 8'h05;
    localparam logic [7:0] CMD_COL_OUT_GO = 8'he0;
    localparam logic [7:0] CMD_DATA_IN = 8'h80;
    localparam logic [7:0] CMD_COL_IN = 8'h85;
    localparam logic [7:0] CMD_PROG_GO = 8'h10;
    localparam logic [7:0] CMD_MULTI_PROG = 8'h11;
    localparam logic [7:0] CMD_MULTI_PROG2 = 8'h81;
    localparam logic [7:0] CMD_ROW_SEL = 8'h60;
    localparam logic [7:0] CMD_ERASE_GO = 8'hd0;
    localparam logic [7:0] CMD_ID = 8'h90;
    localparam logic [7:0] CMD_STATUS = 8'h70;
    localparam logic [7:0] CMD_MSTATUS = 8'h71;
    localparam logic [7:0] CMD_ECC = 8'h7a;
    localparam logic [7:0] CMD_RESET = 8'hff;

    typedef enum logic [2:0] {OP_READ, OP_COLCHG, OP_MULTI, OP_STATUS, OP_ECC, OP_RESET} op_t;
    typedef enum logic [2:0] {S_IDLE, S_SETUP, S_WE_LOW, S_WE_HIGH, S_BUSY, S_GAP, S_RE_LOW, S_RE_HIGH} state_t;
endpackage : nand_host_pkg

// >>> nand_host_sva.sv
// assertions on the flash host pins and command port
`timescale 1ns/1ps
module nand_host_sva (
    input logic sys_clk,
    input logic reset,
    input logic cmd_valid,
    input nand_host_pkg::op_t cmd_op,
    input logic [16:0] cmd_row,
    input logic [16:0] cmd_row2,
    input logic cmd_ready,
    input logic cmd_error,
    input logic command_latch_en,
    input logic address_latch_en,
    input logic write_strobe_n,
    input logic read_strobe_n,
    input logic [7:0] io_bus_out,
    input logic io_bus_oe,
    input logic ready_busy_n
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    logic we_r, cr_r, multi_r;
    logic [2:0] acnt_r;
    logic [7:0] last_r;
    wire lat = write_strobe_n && !we_r;
    // address byte position since last command; last read multi
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            we_r <= 1'b1;
            cr_r <= 1'b1;
            multi_r <= 1'b0;
            acnt_r <= 3'h0;
            last_r <= 8'hff;
        end else begin
            we_r <= write_strobe_n;
            cr_r <= cmd_ready;
            if (lat && command_latch_en) begin
                acnt_r <= (io_bus_out == 8'h60) ? 3'h2 : 3'h0; // row-only address starts at byte three
                last_r <= io_bus_out;
            end else if (lat && address_latch_en) begin
                acnt_r <= acnt_r + 3'h1;
            end
            // op still held as ready falls
            if (cr_r && !cmd_ready && cmd_op inside {nand_host_pkg::OP_MULTI, nand_host_pkg::OP_READ}) begin
                multi_r <= (cmd_op == nand_host_pkg::OP_MULTI);
            end
        end
    end
    write_qual_a: assert property (!write_strobe_n |-> io_bus_oe && read_strobe_n &&
        (command_latch_en ^ address_latch_en)) else $error("bad write qualifiers");
    read_qual_a: assert property (!read_strobe_n |-> !io_bus_oe && write_strobe_n &&
        !command_latch_en && !address_latch_en) else $error("bad read qualifiers");
    col_high_a: assert property (lat && address_latch_en && acnt_r == 3'h1 |-> io_bus_out[7:5] == 3'h0)
        else $error("column high byte not clean");
    row_top_a: assert property (lat && address_latch_en && acnt_r == 3'h4 |-> io_bus_out[7:1] == 7'h00)
        else $error("fifth address byte not clean");
    addr_count_a: assert property (lat && address_latch_en |-> acnt_r < 3'h5)
        else $error("too many address bytes");
    confirm_order_a: assert property (lat && command_latch_en && io_bus_out == 8'h30 |->
        acnt_r == 3'h5 && last_r inside {8'h00, 8'h60}) else $error("confirm out of order");
    busy_cmd_a: assert property (!ready_busy_n [*4] ##1 $fell(write_strobe_n) |->
        command_latch_en && io_bus_out inside {8'h70, 8'hff}) else $error("strobe during busy");
    multi_page_a: assert property (cmd_valid && cmd_ready && cmd_op == nand_host_pkg::OP_MULTI &&
        (cmd_row[5:0] != cmd_row2[5:0] || cmd_row[6] == cmd_row2[6]) |=> cmd_error) else $error("bad multi taken");
    ecc_multi_a: assert property (cmd_valid && cmd_ready && cmd_op == nand_host_pkg::OP_ECC && multi_r |=>
        cmd_error && cmd_ready) else $error("ecc after multi taken");
endmodule : nand_host_sva
bind nand_host nand_host_sva i_nand_host_sva (.*);

// >>> nand_host_tb.sv
// self-checking bench for the flash host against the device model
`timescale 1ns/1ps
module nand_host_tb;
    logic sys_clk = 1'b0, reset = 1'b1, cmd_valid = 1'b0, write_allow = 1'b1, rd_ready = 1'b1;
    nand_host_pkg::op_t cmd_op = nand_host_pkg::OP_STATUS;
    logic [12:0] cmd_col = 13'h0, cmd_count = 13'h0;
    logic [16:0] cmd_row = 17'h0, cmd_row2 = 17'h0;
    logic cmd_ready, cmd_error, cmd_done, rd_valid, command_latch_en, address_latch_en, chip_en_n;
    logic write_strobe_n, read_strobe_n, write_protect_n, io_bus_oe, ready_busy_n, busy_pull;
    logic [7:0] rd_data, io_bus_out, io_bus_in, io_drive;
    logic [7:0] got[$];
    int errors = 0, total_checks = 0, falls = 0;
    always #12.5 sys_clk = ~sys_clk;
    // pull-up on busy; bus echoes the host while it drives
    assign ready_busy_n = !busy_pull;
    assign io_bus_in = io_bus_oe ? io_bus_out : io_drive;
    nand_host i_nand_host (.*);
    nand_flash_model i_nand_flash_model (.*);
    // byte sink and count of array transfers
    always @(posedge sys_clk) if (rd_valid === 1'b1 && rd_ready === 1'b1) got.push_back(rd_data);
    always @(negedge ready_busy_n) falls++;
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // one request, judged the cycle after it is taken
    task automatic issue(input nand_host_pkg::op_t op, input logic [12:0] col, input logic [16:0] r1, r2,
        input logic [12:0] n, input logic bad, wt);
        got.delete();
        @(posedge sys_clk);
        cmd_valid <= 1'b1;
        cmd_op <= op;
        cmd_col <= col;
        cmd_row <= r1;
        cmd_row2 <= r2;
        cmd_count <= n;
        @(posedge sys_clk);
        cmd_valid <= 1'b0;
        #1;
        check({cmd_error, cmd_ready}, {bad, bad});
        for (int i = 0; i < 4000 && wt && !bad && cmd_done !== 1'b1; i++) begin
            @(posedge sys_clk);
            #1;
        end
        if (wt && !bad) check(cmd_done, 1'b1);
    endtask : issue
    task automatic expect_bytes(input logic [7:0] first, input int n);
        repeat (20) @(posedge sys_clk);
        check(got.size(), n);
        for (int i = 0; i < n; i++) check(got[i], 8'(first + i));
    endtask : expect_bytes
    // read near page end, then column change
    task automatic t_read;
        int f;
        f = falls;
        issue(nand_host_pkg::OP_READ, 13'h107e, 17'h1_0203, '0, 13'h2, '0, '1);
        check(falls - f, 1);
        expect_bytes(8'h81, 2);
        issue(nand_host_pkg::OP_COLCHG, 13'h0005, '0, '0, 13'h3, '0, '1);
        check(falls - f, 1);
        expect_bytes(8'h08, 3);
    endtask : t_read
    // fill until the host stalls, then drain
    task automatic t_fifo;
        @(posedge sys_clk);
        rd_ready <= 1'b0;
        issue(nand_host_pkg::OP_READ, 13'h0010, 17'h0_0020, '0, 13'hc, '0, '0);
        repeat (300) @(posedge sys_clk);
        #1;
        check({rd_valid, read_strobe_n, cmd_ready}, 3'b100);
        for (int i = 0; i < 400 && cmd_done !== 1'b1; i++) begin
            @(posedge sys_clk);
            rd_ready <= i[0];
            #1;
        end
        @(posedge sys_clk);
        rd_ready <= 1'b1;
        expect_bytes(8'h30, 12);
    endtask : t_fifo
    // multi reads, refusals, status, ecc, reset
    task automatic t_multi;
        issue(nand_host_pkg::OP_MULTI, '0, 17'h1_00c7, 17'h0_0087, 13'h2, '0, '1);
        expect_bytes(8'h1c + 8'h87, 2);
        issue(nand_host_pkg::OP_MULTI, '0, 17'h0_0087, 17'h1_00c7, 13'h2, '0, '1);
        expect_bytes(8'h1e + 8'hc7, 2);
        issue(nand_host_pkg::OP_ECC, '0, '0, '0, 13'h1, '1, '1);
        issue(nand_host_pkg::OP_MULTI, '0, 17'h0_0007, 17'h0_0087, 13'h1, '1, '1);
        issue(nand_host_pkg::OP_MULTI, '0, 17'h0_0001, 17'h0_0042, 13'h1, '1, '1);
        issue(nand_host_pkg::OP_STATUS, '0, '0, '0, 13'h1, '0, '1);
        expect_bytes(8'he0, 1);
        issue(nand_host_pkg::OP_READ, '0, '0, '0, '0, '0, '1);
        issue(nand_host_pkg::OP_ECC, '0, '0, '0, 13'h1, '0, '1);
        expect_bytes(8'h00, 1);
        issue(nand_host_pkg::OP_RESET, '0, '0, '0, '0, '0, '1);
    endtask : t_multi
    task automatic end_of_test;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : end_of_test
    // reset, scenarios, verdict
    initial begin
        repeat (8) @(posedge sys_clk);
        reset <= 1'b0;
        t_read();
        t_fifo();
        t_multi();
        end_of_test();
    end
    // watchdog far beyond the run's length
    initial begin
        #500_000;
        errors++;
        end_of_test();
    end
endmodule : nand_host_tb

// >>> pin_sync.sv
// two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 1
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sync_t;
    sync_t r, r_nxt;

    // first stage feeds only the second
    always_comb begin
        r_nxt = r;
        r_nxt.s1 = d;
        r_nxt.s2 = r.s1;
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            r <= '1; // idle high, so busy pin reads ready out of reset
        end else begin
            r <= r_nxt;
        end
    end

    assign q = r.s2;
endmodule : pin_sync
